// ### design/kwu_pkg.sv
package kwu_pkg;

    localparam int KEY_COUNT = 8;
    localparam int POL_LSB   = 4;
    localparam int POL_COUNT = 4;
    localparam int ADDR_W    = 5;

    // Pins that also carry an analog converter channel
    localparam logic [7:0] ANALOG_KEYS = 8'hE0;

    // Register byte offsets
    localparam logic [4:0] OFF_CTRL       = 5'h00;
    localparam logic [4:0] OFF_PIN_EN     = 5'h04;
    localparam logic [4:0] OFF_IRQ_STATUS = 5'h08;
    localparam logic [4:0] OFF_IRQ_CLEAR  = 5'h0C;
    localparam logic [4:0] OFF_IRQ_ENABLE = 5'h10;

    // Control register fields
    localparam int CTRL_FLAG_BIT = 3;
    localparam int CTRL_ACK_BIT  = 2;
    localparam int CTRL_IE_BIT   = 1;
    localparam int CTRL_MODE_BIT = 0;

    // Status, clear and enable register layout
    localparam int IRQ_KEY_BIT  = 0;
    localparam int IRQ_WAKE_BIT = 1;

    // Reset values
    localparam logic [3:0] RST_POL    = 4'h0;
    localparam logic [7:0] RST_PIN_EN = 8'h00;
    localparam logic [1:0] RST_IRQ    = 2'h0;

    typedef struct packed {
        logic [7:0] dir;
        logic [7:0] pull_en;
        logic [7:0] out;
        logic [7:0] analog;
    } kwu_port_t;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] pull_up;
        logic [7:0] pull_down;
    } kwu_pad_t;

    typedef struct packed {
        logic [3:0]  pol;
        logic        mode;
        logic [7:0]  pin_en;
        logic [1:0]  status;
        logic [1:0]  irq_en;
        logic [7:0]  prev;
        logic        done;
        logic [31:0] rdata;
    } kwu_state_t;

    localparam kwu_state_t KWU_STATE_RST = '{
        pol:    RST_POL,
        mode:   1'b0,
        pin_en: RST_PIN_EN,
        status: RST_IRQ,
        irq_en: RST_IRQ,
        prev:   8'h00,
        done:   1'b0,
        rdata:  32'h0000_0000
    };

endpackage

// ### design/kwu_pin.sv
`timescale 1ns/100ps
`default_nettype none
module kwu_pin #(
    parameter bit HAS_ANALOG = 1'b0,
    parameter bit HAS_POL    = 1'b0
) (
    // Configuration
    input  wire logic key_en,
    input  wire logic pol_sel,
    input  wire logic analog_sel,
    // Port side
    input  wire logic dir,
    input  wire logic pull_en,
    input  wire logic port_out,
    output logic      port_rd,
    // Pad side
    input  wire logic pad_in,
    output logic      pad_out,
    output logic      pad_oe,
    output logic      pull_up,
    output logic      pull_down,
    // Key side
    output logic      key_hit
);

    logic analog;
    logic pol;

    assign analog   = HAS_ANALOG && analog_sel;
    assign pol      = HAS_POL && pol_sel;
    assign pad_out  = port_out;
    assign pad_oe   = !analog && !key_en && dir;
    assign pull_up   = !analog && pull_en && (key_en ? !pol : !dir);
    assign pull_down = !analog && pull_en && key_en && pol;
    // Pin level reaches the port data register even with the key enabled
    assign port_rd  = analog ? 1'b0 : pad_in;
    assign key_hit  = !analog && key_en && (pol ? pad_in : !pad_in);

endmodule
`default_nettype wire

// ### design/kwu_top.sv
// The address map and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module kwu_top
    import kwu_pkg::*;
#(
    parameter int KEYS = KEY_COUNT
) (
    // Clock and reset
    input  wire logic              REF_CLK,
    input  wire logic              RSTN,
    // Avalon-MM slave
    input  wire logic [ADDR_W-1:0] AVS_ADDRESS,
    input  wire logic              AVS_READ,
    input  wire logic              AVS_WRITE,
    input  wire logic [3:0]        AVS_BYTEENABLE,
    input  wire logic [31:0]       AVS_WRITEDATA,
    output logic      [31:0]       AVS_READDATA,
    output logic                   AVS_WAITREQUEST,
    // Shared port configuration and read-back
    input  wire kwu_port_t         PORT_CFG,
    output logic      [7:0]        PORT_READ_DATA,
    // Pads
    input  wire logic [7:0]        PAD_IN,
    output kwu_pad_t               PAD_DRIVE,
    // Power modes and requests
    input  wire logic              WAIT_MODE,
    input  wire logic              DEEP_STOP_MODE,
    output logic                   WAKE_REQ,
    output logic                   IRQ
);

    ////////////////////////////////////////////////////////////////////////////
    // Parameter check

    generate
        if (KEYS != KEY_COUNT) begin : g_bad_keys
            $error("kwu_top serves exactly eight key inputs");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Pin sharing

    kwu_state_t s;
    kwu_state_t n;
    logic [7:0] key_hit;
    logic [7:0] pol_full;
    logic [7:0] pad_out;
    logic [7:0] pad_oe;
    logic [7:0] pad_pu;
    logic [7:0] pad_pd;

    // Keys below the polarity field have no selection bit
    assign pol_full = {s.pol, 4'h0};

    genvar gi;
    generate
        for (gi = 0; gi < KEY_COUNT; gi++) begin : g_pin
            kwu_pin #(
                .HAS_ANALOG (ANALOG_KEYS[gi]),
                .HAS_POL    (gi >= POL_LSB)
            ) u_pin (
                .key_en     (s.pin_en[gi]),
                .pol_sel    (pol_full[gi]),
                .analog_sel (PORT_CFG.analog[gi]),
                .dir        (PORT_CFG.dir[gi]),
                .pull_en    (PORT_CFG.pull_en[gi]),
                .port_out   (PORT_CFG.out[gi]),
                .port_rd    (PORT_READ_DATA[gi]),
                .pad_in     (PAD_IN[gi]),
                .pad_out    (pad_out[gi]),
                .pad_oe     (pad_oe[gi]),
                .pull_up    (pad_pu[gi]),
                .pull_down  (pad_pd[gi]),
                .key_hit    (key_hit[gi])
            );
        end
    endgenerate

    assign PAD_DRIVE = '{out: pad_out, oe: pad_oe, pull_up: pad_pu, pull_down: pad_pd};

    ////////////////////////////////////////////////////////////////////////////
    // Detection, bus and registers

    logic       req;
    logic       acc;
    logic       wr_ok;
    logic       wr_ctrl;
    logic       wr_pin_en;
    logic       wr_clear;
    logic       wr_enable;
    logic [7:0] key_edge;
    logic       level_any;
    logic       key_set;
    logic       key_ack;
    logic       wake_clr;
    logic [7:0] ctrl_rd;
    logic [31:0] rd_mux;

    assign req   = AVS_READ || AVS_WRITE;
    // One wait state: the access completes in the cycle after it is seen
    assign acc   = req && s.done;
    assign wr_ok = AVS_WRITE && s.done && AVS_BYTEENABLE[0];

    assign wr_ctrl   = wr_ok && (AVS_ADDRESS == OFF_CTRL);
    assign wr_pin_en = wr_ok && (AVS_ADDRESS == OFF_PIN_EN);
    assign wr_clear  = wr_ok && (AVS_ADDRESS == OFF_IRQ_CLEAR);
    assign wr_enable = wr_ok && (AVS_ADDRESS == OFF_IRQ_ENABLE);

    // Previous sample is held as asserted level, so an edge is 0 then 1 here
    assign key_edge  = key_hit & ~s.prev;
    assign level_any = |key_hit;

    // Clocks stop in deep stop, so the level path stands in for the edge path
    always_comb begin
        if (DEEP_STOP_MODE) begin
            key_set = level_any;
        end else begin
            key_set = (|key_edge) || (s.mode && level_any);
        end
    end

    assign key_ack = (wr_ctrl && AVS_WRITEDATA[CTRL_ACK_BIT])
                  || (wr_clear && AVS_WRITEDATA[IRQ_KEY_BIT]);
    assign wake_clr = wr_clear && AVS_WRITEDATA[IRQ_WAKE_BIT];

    // Acknowledge bit is write-only and always reads zero
    assign ctrl_rd = {s.pol, s.status[IRQ_KEY_BIT], 1'b0, s.irq_en[IRQ_KEY_BIT], s.mode};

    always_comb begin
        case (AVS_ADDRESS)
            OFF_CTRL:       rd_mux = {24'h000000, ctrl_rd};
            OFF_PIN_EN:     rd_mux = {24'h000000, s.pin_en};
            OFF_IRQ_STATUS: rd_mux = {30'h00000000, s.status};
            OFF_IRQ_ENABLE: rd_mux = {30'h00000000, s.irq_en};
            default:        rd_mux = 32'h0000_0000;
        endcase
    end

    always_comb begin
        n = s;
        n.done = req && !s.done;
        if (req && !s.done) begin
            n.rdata = rd_mux;
        end
        n.prev = key_hit;
        if (wr_ctrl) begin
            n.pol                 = AVS_WRITEDATA[POL_LSB +: POL_COUNT];
            n.mode                = AVS_WRITEDATA[CTRL_MODE_BIT];
            n.irq_en[IRQ_KEY_BIT] = AVS_WRITEDATA[CTRL_IE_BIT];
        end
        if (wr_pin_en) begin
            n.pin_en = AVS_WRITEDATA[7:0];
        end
        if (wr_enable) begin
            n.irq_en = AVS_WRITEDATA[1:0];
        end
        // A set in the same cycle as a clear wins
        n.status[IRQ_KEY_BIT]  = key_set || (s.status[IRQ_KEY_BIT] && !key_ack);
        n.status[IRQ_WAKE_BIT] = WAKE_REQ || (s.status[IRQ_WAKE_BIT] && !wake_clr);
    end

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            s <= KWU_STATE_RST;
        end else begin
            s <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign AVS_WAITREQUEST = req && !s.done;
    assign AVS_READDATA    = s.rdata;
    assign IRQ             = |(s.status & s.irq_en);
    // Deep stop path is combinational from the pads so it works without a clock
    assign WAKE_REQ = (DEEP_STOP_MODE && level_any)
                   || (WAIT_MODE && s.status[IRQ_KEY_BIT] && s.irq_en[IRQ_KEY_BIT]);

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);

    sequence seq_idle_keys;
        (key_hit == 8'h00) && !DEEP_STOP_MODE;
    endsequence

    sequence seq_key_asserts;
        key_hit != 8'h00;
    endsequence

    sequence seq_ack_write;
        wr_ctrl && AVS_WRITEDATA[CTRL_ACK_BIT] && !key_set;
    endsequence

    a_edge_sets_flag: assert property (
        seq_idle_keys ##1 seq_key_asserts |=> s.status[IRQ_KEY_BIT])
        else $error("key edge did not set the event flag");

    a_level_holds_flag: assert property (
        (s.mode && !DEEP_STOP_MODE && level_any) ##1 (level_any && key_ack)
        |=> s.status[IRQ_KEY_BIT])
        else $error("flag cleared while a key stayed asserted");

    a_ack_clears_flag: assert property (
        s.status[IRQ_KEY_BIT] ##0 seq_ack_write |=> !s.status[IRQ_KEY_BIT])
        else $error("acknowledge did not clear the event flag");

    a_ack_reads_zero: assert property (
        (AVS_READ && acc && AVS_ADDRESS == OFF_CTRL) |-> !AVS_READDATA[CTRL_ACK_BIT])
        else $error("acknowledge bit read back as one");

    a_irq_needs_enable: assert property (
        (s.irq_en == 2'h0) |-> !IRQ)
        else $error("interrupt raised with all enables clear");

    a_irq_follows_flag: assert property (
        (wr_ctrl && AVS_WRITEDATA[CTRL_IE_BIT] && s.status[IRQ_KEY_BIT] && !key_ack)
        |=> IRQ)
        else $error("enabled event flag gave no interrupt");

    a_deep_stop_wake: assert property (
        (DEEP_STOP_MODE && key_hit != 8'h00) |-> WAKE_REQ ##1 s.status[IRQ_KEY_BIT])
        else $error("asserted key did not wake from deep stop");

    a_wait_wake: assert property (
        (WAIT_MODE && IRQ && s.irq_en[IRQ_WAKE_BIT] == 1'b0) |-> WAKE_REQ)
        else $error("key interrupt did not wake from wait");

    a_key_forces_input: assert property (
        (s.pin_en & PAD_DRIVE.oe) == 8'h00)
        else $error("enabled key pin is being driven");

    a_pull_exclusive: assert property (
        ((PAD_DRIVE.pull_up & PAD_DRIVE.pull_down) == 8'h00)
        && ((PAD_DRIVE.pull_down & ~s.pin_en) == 8'h00))
        else $error("pull resistors in conflict");

    a_fixed_polarity: assert property (
        (PAD_DRIVE.pull_down[3:0] == 4'h0))
        else $error("fixed-polarity key got a pulldown");

    a_analog_off: assert property (
        ((PORT_CFG.analog & ANALOG_KEYS
          & (PAD_DRIVE.oe | PAD_DRIVE.pull_up | PAD_DRIVE.pull_down | key_hit
             | PORT_READ_DATA)) == 8'h00))
        else $error("analog pin still has port or key function");

    a_one_wait_state: assert property (
        (req && !s.done) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
        else $error("bus access did not finish after one wait state");

endmodule
`default_nettype wire

// ### bench/kwu_keys.sv
`timescale 1ns/100ps
`default_nettype none
module kwu_keys
    import kwu_pkg::*;
(
    // Clock
    input  wire logic       clk,
    // Pad drive and key state
    input  wire kwu_pad_t   drive,
    input  wire logic [7:0] press,
    input  wire logic [7:0] level,
    // Resolved pad levels
    output logic [7:0]      pad
);
    logic [7:0] last_r;
    logic [7:0] held;

    ////////////////////////////////////////////////////////////////////////////////
    // A floating pin shows the inverse of its last settled level, so no default hides a fault
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            held[i] = drive.oe[i] | press[i] | drive.pull_up[i] | drive.pull_down[i];
            if (drive.oe[i]) begin
                pad[i] = drive.out[i];
            end else if (press[i]) begin
                pad[i] = level[i];
            end else if (drive.pull_up[i]) begin
                pad[i] = 1'b1;
            end else if (drive.pull_down[i]) begin
                pad[i] = 1'b0;
            end else begin
                pad[i] = ~last_r[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        for (int i = 0; i < 8; i++) begin
            if (held[i]) begin
                last_r[i] <= pad[i];
            end
        end
    end
endmodule
`default_nettype wire

// ### bench/kwu_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define KWU_CHK(name, exp, got) begin num_checks++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("MISMATCH %s expected %0h seen %0h", name, exp, got); end end
module kwu_top_tb;
    import kwu_pkg::*;
    typedef struct packed {
        kwu_port_t  cfg;
        logic [7:0] en;
        logic [3:0] pol;
        logic [7:0] pu;
        logic [7:0] pd;
        logic [7:0] oe;
        logic [7:0] rdv;
    } kwu_row_t;
    logic              ref_clk;
    logic              rstn;
    logic [ADDR_W-1:0] address;
    logic              read;
    logic              write;
    logic [3:0]        byteenable;
    logic [31:0]       writedata;
    logic [31:0]       readdata;
    logic              waitrequest;
    kwu_port_t         port_cfg;
    logic [7:0]        port_rd;
    logic [7:0]        pad_in;
    kwu_pad_t          pad_drive;
    logic              wait_mode;
    logic              deep_stop;
    logic              wake_req;
    logic              irq;
    logic [7:0]        key_press;
    logic [7:0]        key_level;
    logic [31:0]       rd;
    int                n_mismatch;
    int                num_checks;
    kwu_row_t          rows [5] = '{
        {32'h00FF_0000, 8'h00, 4'h0, 32'hFF00_00FF},
        {32'hFFFF_A500, 8'h00, 4'h0, 32'h0000_FFA5},
        {32'hFFFF_A500, 8'hFF, 4'hF, 32'h0FF0_000F},
        {32'hFF00_A500, 8'hFF, 4'hA, 32'h0000_00A0},
        {32'h00FF_00FF, 8'hFF, 4'h5, 32'h0F10_000F}};
    logic [4:0]        regs [4] = '{OFF_CTRL, OFF_PIN_EN, OFF_IRQ_STATUS, OFF_IRQ_ENABLE};

    kwu_top kwu_top_i (.REF_CLK(ref_clk), .RSTN(rstn), .AVS_ADDRESS(address), .AVS_READ(read),
        .AVS_WRITE(write), .AVS_BYTEENABLE(byteenable), .AVS_WRITEDATA(writedata),
        .AVS_READDATA(readdata), .AVS_WAITREQUEST(waitrequest), .PORT_CFG(port_cfg),
        .PORT_READ_DATA(port_rd), .PAD_IN(pad_in), .PAD_DRIVE(pad_drive),
        .WAIT_MODE(wait_mode), .DEEP_STOP_MODE(deep_stop), .WAKE_REQ(wake_req), .IRQ(irq));

    kwu_keys kwu_keys_i (.clk(ref_clk), .drive(pad_drive), .press(key_press),
        .level(key_level), .pad(pad_in));

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic report_and_stop();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Waitrequest and read data are taken at the rising edge, before that edge's update lands
    task automatic bus_go(input logic [4:0] a, input logic wr, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        address <= a;
        writedata <= {24'h00_0000, d};
        write <= wr;
        read <= ~wr;
        do begin
            @(posedge ref_clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        if (waitrequest !== 1'b0) begin
            n_mismatch++;
            report_and_stop();
        end
        rd = readdata;
        write <= 1'b0;
        read <= 1'b0;
        @(negedge ref_clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rstn = 1'b0;
        address = 5'h00;
        read = 1'b0;
        write = 1'b0;
        byteenable = 4'hF;
        writedata = 32'h0000_0000;
        port_cfg = '{dir: 8'h00, pull_en: 8'hFF, out: 8'h00, analog: 8'h00};
        wait_mode = 1'b0;
        deep_stop = 1'b0;
        key_press = 8'h00;
        key_level = 8'h00;
        n_mismatch = 0;
        num_checks = 0;
        repeat (20) @(posedge ref_clk);
        rstn <= 1'b1;
        foreach (rows[k]) begin
            bus_go(OFF_PIN_EN, 1'b1, rows[k].en);
            bus_go(OFF_CTRL, 1'b1, {rows[k].pol, 4'h4});
            @(posedge ref_clk);
            port_cfg <= rows[k].cfg;
            bus_go(OFF_PIN_EN, 1'b0, 8'h00);
            `KWU_CHK("pin_en", {24'h00_0000, rows[k].en}, rd)
            `KWU_CHK("pull_up", rows[k].pu, pad_drive.pull_up)
            `KWU_CHK("pull_down", rows[k].pd, pad_drive.pull_down)
            `KWU_CHK("oe", rows[k].oe, pad_drive.oe)
            `KWU_CHK("port_rd", rows[k].rdv, port_rd)
        end
        // Falling edge on key zero, edge-only, interrupt masked
        @(posedge ref_clk);
        port_cfg <= '{dir: 8'h00, pull_en: 8'hFF, out: 8'h00, analog: 8'h00};
        bus_go(OFF_PIN_EN, 1'b1, 8'h01);
        bus_go(OFF_CTRL, 1'b1, 8'h04);
        bus_go(OFF_CTRL, 1'b0, 8'h00);
        `KWU_CHK("ctrl idle", 32'h0000_0000, rd)
        @(posedge ref_clk);
        key_press <= 8'h01;
        repeat (2) @(posedge ref_clk);
        bus_go(OFF_CTRL, 1'b0, 8'h00);
        `KWU_CHK("flag fall", 32'h0000_0008, rd)
        `KWU_CHK("irq masked", 1'b0, irq)
        bus_go(OFF_CTRL, 1'b1, 8'h04);
        bus_go(OFF_CTRL, 1'b0, 8'h00);
        `KWU_CHK("ack edge", 32'h0000_0000, rd)
        // Level mode keeps the flag while held
        @(posedge ref_clk);
        wait_mode <= 1'b1;
        bus_go(OFF_CTRL, 1'b1, 8'h07);
        bus_go(OFF_CTRL, 1'b0, 8'h00);
        `KWU_CHK("flag held", 32'h0000_000B, rd)
        `KWU_CHK("irq on", 1'b1, irq)
        `KWU_CHK("wake wait", 1'b1, wake_req)
        bus_go(OFF_IRQ_STATUS, 1'b0, 8'h00);
        `KWU_CHK("status", 1'b1, rd[0])
        bus_go(OFF_IRQ_ENABLE, 1'b0, 8'h00);
        `KWU_CHK("enable", 1'b1, rd[0])
        // Acknowledge while the key is still held in level mode must not clear the flag
        bus_go(OFF_CTRL, 1'b1, 8'h07);
        bus_go(OFF_CTRL, 1'b0, 8'h00);
        `KWU_CHK("ack held", 32'h0000_000B, rd)
        @(posedge ref_clk);
        key_press <= 8'h00;
        wait_mode <= 1'b0;
        bus_go(OFF_IRQ_CLEAR, 1'b1, 8'h01);
        bus_go(OFF_CTRL, 1'b0, 8'h00);
        `KWU_CHK("cleared", 32'h0000_0003, rd)
        `KWU_CHK("irq off", 1'b0, irq)
        bus_go(OFF_IRQ_ENABLE, 1'b1, 8'h00);
        bus_go(OFF_CTRL, 1'b0, 8'h00);
        `KWU_CHK("ie shared", 32'h0000_0001, rd)
        // Rising polarity on key four; a disabled key is ignored
        bus_go(OFF_PIN_EN, 1'b1, 8'h10);
        bus_go(OFF_CTRL, 1'b1, 8'h14);
        @(posedge ref_clk);
        key_press <= 8'h02;
        repeat (2) @(posedge ref_clk);
        bus_go(OFF_CTRL, 1'b0, 8'h00);
        `KWU_CHK("off key", 32'h0000_0010, rd)
        @(posedge ref_clk);
        key_press <= 8'h10;
        key_level <= 8'h10;
        repeat (2) @(posedge ref_clk);
        bus_go(OFF_CTRL, 1'b0, 8'h00);
        `KWU_CHK("flag rise", 32'h0000_0018, rd)
        // Deep stop wake follows the level directly
        @(posedge ref_clk);
        key_press <= 8'h00;
        deep_stop <= 1'b1;
        bus_go(OFF_CTRL, 1'b1, 8'h14);
        `KWU_CHK("no wake", 1'b0, wake_req)
        @(posedge ref_clk);
        key_press <= 8'h10;
        @(negedge ref_clk);
        `KWU_CHK("wake stop", 1'b1, wake_req)
        @(posedge ref_clk);
        key_press <= 8'h00;
        deep_stop <= 1'b0;
        // Unmapped place and a write without its byte lane
        bus_go(5'h14, 1'b1, 8'hFF);
        bus_go(5'h14, 1'b0, 8'h00);
        `KWU_CHK("unmapped", 32'h0000_0000, rd)
        @(posedge ref_clk);
        byteenable <= 4'hE;
        bus_go(OFF_PIN_EN, 1'b1, 8'hFF);
        @(posedge ref_clk);
        byteenable <= 4'hF;
        bus_go(OFF_PIN_EN, 1'b0, 8'h00);
        `KWU_CHK("no lane", 32'h0000_0010, rd)
        // Raise the interrupt first so that the reset below has something to clear
        bus_go(OFF_CTRL, 1'b1, 8'h12);
        `KWU_CHK("irq pre", 1'b1, irq)
        // Reset in mid-run
        @(posedge ref_clk);
        rstn <= 1'b0;
        @(posedge ref_clk);
        rstn <= 1'b1;
        @(negedge ref_clk);
        `KWU_CHK("irq reset", 1'b0, irq)
        foreach (regs[k]) begin
            bus_go(regs[k], 1'b0, 8'h00);
            `KWU_CHK("reset value", 32'h0000_0000, rd)
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
